// *** hw/charge_gauge.sv ***
// Measurement sequencer, charge counter and gauge parameter registers.
// Assumes an APB master on clock, a free running time base pin and a
// shared converter whose result settles before each slot ends.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps

module charge_gauge #(
    parameter int FRAME_TICKS = charge_gauge_pkg::FRAME_TICKS,
    parameter int VT_TICKS = charge_gauge_pkg::VT_TICKS,
    parameter int CURR_TICKS = charge_gauge_pkg::CURR_TICKS
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timebase_in,
    input wire logic [15:0] conv_data,
    output charge_gauge_pkg::conv_t conv_kind,
    output logic voltage_only_select
);

    localparam logic [19:0] FRAME_LAST = 20'(FRAME_TICKS - 1);
    localparam logic [19:0] VT_LAST = 20'(VT_TICKS - 1);
    localparam logic [19:0] CURR_LAST = 20'(CURR_TICKS - 1);
    localparam logic [19:0] CURR_LEN = 20'(CURR_TICKS);

    typedef struct packed {
        logic tb1;
        logic tb2;
        logic tb3;
        logic [15:0] d1;
        logic [15:0] d2;
        charge_gauge_pkg::conv_t st;
        logic [19:0] frame_cnt;
        logic [19:0] slot_cnt;
        logic [1:0] frame_idx;
        logic vonly;
        logic [11:0] volt;
        logic [7:0] temp;
        logic [13:0] cur;
        logic [15:0] avg;
        logic [31:0] acc;
        logic [15:0] cnt;
        logic [15:0] soc;
        logic [15:0] soc_prev;
        logic [15:0] ccs;
        logic [11:0] vmp;
        logic [15:0] ocv;
        logic [15:0][15:0] ocvtab;
        logic [15:0][15:0] soctab;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic tick;
    logic frame_end;
    logic slot_last;
    logic room;
    logic cur_done;
    logic volt_done;
    logic apb_wr;
    logic [15:0] avg_target;
    logic [15:0] soc_vm;
    logic [15:0] rate_sample;
    logic signed [16:0] ocv_diff;
    logic signed [31:0] vm_prod;
    logic signed [31:0] cc_prod;
    logic [31:0] rd_val;
    logic rd_err;

    // ==========================================================
    // Sequencer, arithmetic and register file
    always_comb begin
        s_nxt = s_r;
        // Pin inputs pass two flops; data reads the second stage, the time base edge also a third
        s_nxt.tb1 = timebase_in;
        s_nxt.tb2 = s_r.tb1;
        s_nxt.tb3 = s_r.tb2;
        s_nxt.d1 = conv_data;
        s_nxt.d2 = s_r.d1;
        tick = s_r.tb2 & ~s_r.tb3;

        frame_end = tick && s_r.frame_cnt == FRAME_LAST;
        slot_last = tick && s_r.slot_cnt ==
            ((s_r.st == charge_gauge_pkg::CURR) ? CURR_LAST : VT_LAST);
        // A current conversion must end inside the frame
        room = (s_r.frame_cnt + CURR_LEN) <= FRAME_LAST;
        cur_done = slot_last && s_r.st == charge_gauge_pkg::CURR;
        volt_done = slot_last && s_r.st == charge_gauge_pkg::VOLT;

        if (tick) begin
            s_nxt.frame_cnt = frame_end ? '0 : s_r.frame_cnt + 20'h00001;
            s_nxt.slot_cnt = s_r.slot_cnt + 20'h00001;
        end

        if (slot_last) begin
            s_nxt.slot_cnt = '0;
            unique case (s_r.st)
                charge_gauge_pkg::TEMP: begin
                    s_nxt.temp = s_r.d2[7:0];
                    s_nxt.st = charge_gauge_pkg::VOLT;
                end
                charge_gauge_pkg::VOLT, charge_gauge_pkg::CURR: begin
                    // Back to current only in mixed mode
                    s_nxt.st = (!s_r.vonly && room) ?
                        charge_gauge_pkg::CURR : charge_gauge_pkg::IDLE;
                end
                charge_gauge_pkg::IDLE: s_nxt.st = charge_gauge_pkg::IDLE;
            endcase
        end

        // Frame start: temperature every fourth frame, voltage always
        if (frame_end) begin
            s_nxt.slot_cnt = '0;
            s_nxt.frame_idx = s_r.frame_idx + 2'h1;
            s_nxt.st = (s_r.frame_idx == charge_gauge_pkg::TEMP_EVERY) ?
                charge_gauge_pkg::TEMP : charge_gauge_pkg::VOLT;
        end

        // Voltage model: estimate chases the measured voltage
        ocv_diff = 17'($signed({5'h00, s_r.d2[11:0]})) -
            $signed({1'b0, s_r.ocv});
        vm_prod = 32'(ocv_diff * $signed({1'b0, s_r.vmp}));
        soc_vm = '0;
        for (int i = 0; i < charge_gauge_pkg::TAB_ENTRIES; i++) begin
            if (s_r.ocv >= s_r.ocvtab[i]) begin
                soc_vm = s_r.soctab[i];
            end
        end
        rate_sample = soc_vm - s_r.soc_prev;

        if (volt_done) begin
            s_nxt.volt = s_r.d2[11:0];
            s_nxt.ocv = s_r.ocv +
                vm_prod[charge_gauge_pkg::VM_SHIFT+15:charge_gauge_pkg::VM_SHIFT];
            if (s_r.vonly) begin
                s_nxt.soc = soc_vm;
                s_nxt.soc_prev = soc_vm;
                // 64 s over 4 s steps gives a 1/16 filter
                s_nxt.avg = s_r.avg + 16'($signed(rate_sample - s_r.avg) >>>
                    charge_gauge_pkg::RATE_SHIFT);
            end
        end

        // Quarter-step sample, filtered over four 500 ms results
        avg_target = {{2{s_r.d2[13]}}, s_r.d2[13:0]} << 2;
        cc_prod = $signed(s_r.d2[13:0]) * $signed({1'b0, s_r.ccs});
        if (cur_done) begin
            s_nxt.cur = s_r.d2[13:0];
            s_nxt.acc = s_r.acc + {{18{s_r.d2[13]}}, s_r.d2[13:0]};
            s_nxt.cnt = s_r.cnt + 16'h0001;
            s_nxt.soc = s_r.soc +
                cc_prod[charge_gauge_pkg::CC_SHIFT+15:charge_gauge_pkg::CC_SHIFT];
            s_nxt.avg = s_r.avg + 16'($signed(avg_target - s_r.avg) >>>
                charge_gauge_pkg::AVG_SHIFT);
        end

        // APB: answer in first access cycle, data prepared at setup
        rd_err = 1'b0;
        rd_val = '0;
        unique case (paddr)
            charge_gauge_pkg::CTRL_OFS: rd_val = {31'h0, s_r.vonly};
            charge_gauge_pkg::VOLTAGE_OFS: rd_val = {20'h0, s_r.volt};
            charge_gauge_pkg::TEMPERATURE_OFS: rd_val = {{24{s_r.temp[7]}}, s_r.temp};
            charge_gauge_pkg::CURRENT_OFS: rd_val = {{18{s_r.cur[13]}}, s_r.cur};
            charge_gauge_pkg::AVERAGED_OFS: rd_val = {16'h0, s_r.avg};
            charge_gauge_pkg::ACCUM_OFS: rd_val = s_r.acc;
            charge_gauge_pkg::CONV_COUNT_OFS: rd_val = {16'h0, s_r.cnt};
            charge_gauge_pkg::SOC_OFS: rd_val = {16'h0, s_r.soc};
            charge_gauge_pkg::CC_SCALE_OFS: rd_val = {16'h0, s_r.ccs};
            charge_gauge_pkg::VM_PARAM_OFS: rd_val = {20'h0, s_r.vmp};
            charge_gauge_pkg::OCV_OFS: rd_val = {16'h0, s_r.ocv};
            default: begin
                if (paddr[1:0] == 2'h0 &&
                        paddr[7:6] == charge_gauge_pkg::OCV_TAB_PAGE) begin
                    rd_val = {16'h0, s_r.ocvtab[paddr[5:2]]};
                end else if (paddr[1:0] == 2'h0 &&
                        paddr[7:6] == charge_gauge_pkg::SOC_TAB_PAGE) begin
                    rd_val = {16'h0, s_r.soctab[paddr[5:2]]};
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase

        apb_wr = psel && penable && pwrite && s_r.pready && !s_r.pslverr;
        if (psel && !penable) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = rd_err;
            s_nxt.prdata = pwrite ? 32'h0 : rd_val;
        end else begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
        end

        // Host writes come last so they win over a same-cycle update
        if (apb_wr) begin
            unique case (paddr)
                charge_gauge_pkg::CTRL_OFS: s_nxt.vonly = pwdata[0];
                charge_gauge_pkg::AVERAGED_OFS: s_nxt.avg = pwdata[15:0];
                charge_gauge_pkg::SOC_OFS: begin
                    s_nxt.soc = pwdata[15:0];
                    s_nxt.soc_prev = pwdata[15:0];
                    s_nxt.acc = '0;
                end
                charge_gauge_pkg::CC_SCALE_OFS: s_nxt.ccs = pwdata[15:0];
                charge_gauge_pkg::VM_PARAM_OFS: s_nxt.vmp = pwdata[11:0];
                default: begin
                    if (paddr[7:6] == charge_gauge_pkg::OCV_TAB_PAGE) begin
                        s_nxt.ocvtab[paddr[5:2]] = pwdata[15:0];
                    end else if (paddr[7:6] == charge_gauge_pkg::SOC_TAB_PAGE) begin
                        s_nxt.soctab[paddr[5:2]] = pwdata[15:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.st <= charge_gauge_pkg::TEMP;
            s_r.vonly <= charge_gauge_pkg::MODE_RESET;
            s_r.ccs <= charge_gauge_pkg::CC_SCALE_RESET;
            s_r.vmp <= charge_gauge_pkg::VM_PARAM_RESET;
            for (int i = 0; i < charge_gauge_pkg::TAB_ENTRIES; i++) begin
                s_r.ocvtab[i] <= 16'(charge_gauge_pkg::OCV_TAB_BASE +
                    i * charge_gauge_pkg::OCV_TAB_STEP);
                s_r.soctab[i] <= 16'(i * charge_gauge_pkg::SOC_TAB_STEP);
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign conv_kind = s_r.st;
    assign voltage_only_select = s_r.vonly;

    // ==========================================================
    // Checks
    sequence temp_slot_end;
        slot_last && s_r.st == charge_gauge_pkg::TEMP;
    endsequence

    sequence volt_slot_runs;
        s_r.st == charge_gauge_pkg::VOLT && s_r.slot_cnt == 20'h0;
    endsequence

    a_mode_at_reset: assert property (@(posedge clock) disable iff (!resetn)
        !$past(resetn) |-> s_r.vonly &&
        s_r.ccs == charge_gauge_pkg::CC_SCALE_RESET)
        else $error("mode or scale not at reset value");
    a_vm_param_reset: assert property (@(posedge clock) disable iff (!resetn)
        !$past(resetn) |-> s_r.vmp == charge_gauge_pkg::VM_PARAM_RESET)
        else $error("voltage model parameter not at reset value");
    a_temp_then_volt: assert property (@(posedge clock) disable iff (!resetn)
        temp_slot_end and (!frame_end) |=> volt_slot_runs)
        else $error("voltage slot does not follow temperature slot");
    a_vt_slot_hold: assert property (@(posedge clock) disable iff (!resetn)
        s_r.st == charge_gauge_pkg::VOLT && s_r.slot_cnt < VT_LAST &&
        !frame_end |=> s_r.st == charge_gauge_pkg::VOLT)
        else $error("voltage slot ended early");
    a_no_curr_vonly: assert property (@(posedge clock) disable iff (!resetn)
        $changed(s_r.st) && s_r.st == charge_gauge_pkg::CURR |->
        !$past(s_r.vonly))
        else $error("current conversion started in voltage-only mode");
    a_count_step: assert property (@(posedge clock) disable iff (!resetn)
        cur_done |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
        else $error("conversion count did not advance");
    a_current_store: assert property (@(posedge clock) disable iff (!resetn)
        cur_done |=> s_r.cur == $past(s_r.d2[13:0]))
        else $error("current result not stored");
    a_volt_store: assert property (@(posedge clock) disable iff (!resetn)
        volt_done |=> s_r.volt == $past(s_r.d2[11:0]))
        else $error("voltage result not stored");
    a_soc_restart: assert property (@(posedge clock) disable iff (!resetn)
        apb_wr && paddr == charge_gauge_pkg::SOC_OFS |=>
        s_r.soc == $past(pwdata[15:0]) && s_r.acc == 32'h0)
        else $error("state of charge write not applied");

endmodule // charge_gauge

// *** hw/charge_gauge_pkg.sv ***
// Shared constants of the measurement sequencer and charge counter.
// Assumes a 100 MHz system clock and a 32768 Hz time base pin.
package charge_gauge_pkg;

    // ==========================================================
    // Register map (byte offsets on APB)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] VOLTAGE_OFS = 8'h04;
    localparam logic [7:0] TEMPERATURE_OFS = 8'h08;
    localparam logic [7:0] CURRENT_OFS = 8'h0C;
    localparam logic [7:0] AVERAGED_OFS = 8'h10;
    localparam logic [7:0] ACCUM_OFS = 8'h14;
    localparam logic [7:0] CONV_COUNT_OFS = 8'h18;
    localparam logic [7:0] SOC_OFS = 8'h1C;
    localparam logic [7:0] CC_SCALE_OFS = 8'h20;
    localparam logic [7:0] VM_PARAM_OFS = 8'h24;
    localparam logic [7:0] OCV_OFS = 8'h28;
    localparam logic [1:0] OCV_TAB_PAGE = 2'h1;
    localparam logic [1:0] SOC_TAB_PAGE = 2'h2;
    localparam int TAB_ENTRIES = 16;

    // ==========================================================
    // Reset values
    localparam logic MODE_RESET = 1'b1;
    localparam logic [15:0] CC_SCALE_RESET = 16'h018B;
    localparam logic [11:0] VM_PARAM_RESET = 12'h141;
    localparam logic [15:0] OCV_TAB_BASE = 16'h0600;
    localparam logic [15:0] OCV_TAB_STEP = 16'h0020;
    localparam logic [15:0] SOC_TAB_STEP = 16'h0640;

    // ==========================================================
    // Timing
    localparam int TB_HZ = 32768;
    localparam int FRAME_S = 4;
    localparam int TEMP_S = 16;
    localparam int VT_MS = 250;
    localparam int CURR_MS = 500;
    localparam int FRAME_TICKS = TB_HZ * FRAME_S;
    localparam int VT_TICKS = TB_HZ * VT_MS / 1000;
    localparam int CURR_TICKS = TB_HZ * CURR_MS / 1000;
    localparam logic [1:0] TEMP_EVERY = 2'(TEMP_S / FRAME_S - 1);

    // ==========================================================
    // Arithmetic scaling
    localparam int CC_SHIFT = 12;
    localparam int VM_SHIFT = 12;
    localparam int AVG_SHIFT = 2;
    localparam int RATE_SHIFT = 4;

    typedef enum logic [1:0] {
        IDLE = 2'b00,
        TEMP = 2'b01,
        VOLT = 2'b10,
        CURR = 2'b11
    } conv_t;

endpackage

// *** verif/converter_model.sv ***
// Model of the converter and time base facing the measurement sequencer.
// Assumes conv_kind comes from the sequencer under test.
`timescale 1ns/10ps

module converter_model #(
    parameter logic [15:0] VOLT_PIN = 16'hF6A4,
    parameter logic [15:0] TEMP_PIN = 16'hABF6,
    parameter logic [15:0] CURR_PIN = 16'h7FF8
) (
    input wire charge_gauge_pkg::conv_t conv_kind,
    output logic timebase_in,
    output logic [15:0] conv_data
);
    // ==========================================================
    // Time base
    // Free running, phase unrelated to the system clock
    initial begin
        timebase_in = 1'b0;
        #3.3;
        forever #62.5 timebase_in = ~timebase_in;
    end

    // ==========================================================
    // Result bus
    // Junk in unused upper bits so masking gets exercised
    always_comb begin
        case (conv_kind)
            charge_gauge_pkg::VOLT: conv_data = VOLT_PIN;
            charge_gauge_pkg::TEMP: conv_data = TEMP_PIN;
            charge_gauge_pkg::CURR: conv_data = CURR_PIN;
            default: conv_data = ~VOLT_PIN;
        endcase
    end
endmodule // converter_model

// *** verif/tb.sv ***
// Self-checking bench for the measurement sequencer and charge counter.
// Assumes shortened slot parameters and the converter model alongside.
`timescale 1ns/10ps

module tb;
    localparam int FR = 64;
    localparam int VT = 8;
    localparam int CR = 16;
    // Top point of the default charge curve
    localparam logic [15:0] TOP_SOC = 16'((charge_gauge_pkg::TAB_ENTRIES - 1) *
        charge_gauge_pkg::SOC_TAB_STEP);
    logic clock, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic er, timebase_in, voltage_only_select;
    logic [15:0] conv_data;
    charge_gauge_pkg::conv_t conv_kind, prev_kind;
    int error_cnt, cmp_count, run, cyc, tlast, tperiod, t0, t1;
    int starts[4];
    int ends_n[4];
    int len[4];

    charge_gauge #(.FRAME_TICKS(FR), .VT_TICKS(VT), .CURR_TICKS(CR))
    charge_gauge_i (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timebase_in(timebase_in), .conv_data(conv_data),
        .conv_kind(conv_kind), .voltage_only_select(voltage_only_select));

    converter_model converter_model_i (.conv_kind(conv_kind),
        .timebase_in(timebase_in), .conv_data(conv_data));

    // ==========================================================
    // Slot monitor
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (!resetn) begin
            run <= 0;
            prev_kind <= conv_kind;
        end else if (conv_kind !== prev_kind) begin
            len[prev_kind] <= run + 1;
            ends_n[prev_kind] <= ends_n[prev_kind] + 1;
            starts[conv_kind] <= starts[conv_kind] + 1;
            run <= 0;
            prev_kind <= conv_kind;
            if (conv_kind == charge_gauge_pkg::TEMP) begin
                tperiod <= cyc - tlast;
                tlast <= cyc;
            end
        end else begin
            run <= run + 1;
        end
    end

    // ==========================================================
    // Tasks
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(1'b0, 1'b1, "no pready");
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "register read");
    endtask

    // Waits for a slot of kind k to start (e=0) or end (e=1)
    task automatic wait_evt(input int k, input bit e);
        int s0;
        int n;
        s0 = e ? ends_n[k] : starts[k];
        n = 0;
        while ((e ? ends_n[k] : starts[k]) == s0 && n < 8000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 8000) begin
            chk(1'b0, 1'b1, "slot wait");
            stop_test();
        end
    endtask

    // Polls the conversion count until it reads n, noting the cycle
    task automatic wait_cnt(input logic [15:0] n, output int at);
        int k;
        k = 0;
        do begin
            apb(1'b0, charge_gauge_pkg::CONV_COUNT_OFS, 32'h0);
            k++;
        end while (rd[15:0] !== n && k < 400);
        at = cyc;
        if (rd[15:0] !== n) begin
            chk(1'b0, 1'b1, "count wait");
            stop_test();
        end
    endtask

    // Slot counts between two temperature slots, one 4-frame period
    // Back-to-back current slots never change conv_kind, so the
    // conversion count register counts them instead
    task automatic cadence(input int ev, input int ec);
        int v0;
        logic [15:0] c0;
        wait_evt(charge_gauge_pkg::TEMP, 1'b0);
        v0 = starts[charge_gauge_pkg::VOLT];
        apb(1'b0, charge_gauge_pkg::CONV_COUNT_OFS, 32'h0);
        c0 = rd[15:0];
        wait_evt(charge_gauge_pkg::TEMP, 1'b0);
        apb(1'b0, charge_gauge_pkg::CONV_COUNT_OFS, 32'h0);
        chk(32'(starts[charge_gauge_pkg::VOLT] - v0), 32'(ev), "volt n");
        chk({16'h0, 16'(rd[15:0] - c0)}, 32'(ec), "curr n");
        chk(32'(tperiod >= 3197 && tperiod <= 3203), 32'h1, "temp period");
    endtask

    // ==========================================================
    // Stimulus
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {error_cnt, cmp_count, cyc, tlast, tperiod} = '0;
        starts = '{default: 0};
        ends_n = '{default: 0};
        len = '{default: 0};
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        chk(voltage_only_select, 1'b1, "mode pin");
        chk(conv_kind, charge_gauge_pkg::TEMP, "first slot");
        rdchk(charge_gauge_pkg::CTRL_OFS, 32'h1);
        rdchk(charge_gauge_pkg::CC_SCALE_OFS, 32'h18B);
        rdchk(charge_gauge_pkg::VM_PARAM_OFS, 32'h141);
        apb(1'b1, charge_gauge_pkg::VM_PARAM_OFS, 32'hFFFFF2AB);
        rdchk(charge_gauge_pkg::VM_PARAM_OFS, 32'h2AB);
        rdchk(8'h44, 32'h620);
        rdchk(8'h88, 32'hC80);
        apb(1'b1, 8'h44, 32'h777);
        rdchk(8'h44, 32'h777);
        apb(1'b0, 8'hC0, 32'h0);
        chk(er, 1'b1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        // Voltage-only mode: no current slots at all
        cadence(4, 0);
        rdchk(charge_gauge_pkg::VOLTAGE_OFS, 32'h6A4);
        rdchk(charge_gauge_pkg::TEMPERATURE_OFS, 32'hFFFFFFF6);
        rdchk(charge_gauge_pkg::CONV_COUNT_OFS, 32'h0);
        chk(32'(len[2] >= 97 && len[2] <= 103), 32'h1, "volt len");
        chk(32'(len[1] >= 97 && len[1] <= 103), 32'h1, "temp len");
        // Mixed mode, seeding averaged and charge values mid-conversion
        apb(1'b1, charge_gauge_pkg::CTRL_OFS, 32'h0);
        rdchk(charge_gauge_pkg::CTRL_OFS, 32'h0);
        wait_evt(charge_gauge_pkg::CURR, 1'b0);
        chk(voltage_only_select, 1'b0, "mode pin");
        apb(1'b1, charge_gauge_pkg::AVERAGED_OFS, 32'h100);
        apb(1'b1, charge_gauge_pkg::SOC_OFS, 32'h1000);
        // One conversion ends: count, result and seeded values move once
        wait_cnt(16'h0001, t0);
        rdchk(charge_gauge_pkg::CURRENT_OFS, 32'hFFFFFFF8);
        rdchk(charge_gauge_pkg::CONV_COUNT_OFS, 32'h1);
        apb(1'b0, charge_gauge_pkg::ACCUM_OFS, 32'h0);
        chk(rd[15:0], 16'hFFF8, "accumulator");
        apb(1'b0, charge_gauge_pkg::AVERAGED_OFS, 32'h0);
        chk(rd[15:0], 16'h00B8, "average");
        apb(1'b0, charge_gauge_pkg::SOC_OFS, 32'h0);
        chk(rd[15:0], 16'h0FFF, "charge");
        wait_cnt(16'h0002, t1);
        chk(32'(t1 - t0 inside {[196:204]}), 32'h1, "curr time");
        cadence(4, 12);
        // Three back-to-back conversions show as one run of conv_kind
        chk(32'(len[3] inside {[597:603]}), 32'h1, "curr len");
        apb(1'b1, charge_gauge_pkg::CTRL_OFS, 32'h1);
        cadence(4, 0);
        // Flat curve: model charge is the top point, so the rate is known
        for (int i = 0; i < charge_gauge_pkg::TAB_ENTRIES; i++) begin
            apb(1'b1, 8'(8'h40 + 4 * i), 32'h0);
        end
        apb(1'b1, charge_gauge_pkg::SOC_OFS,
            {16'h0, TOP_SOC - 16'h0100});
        apb(1'b1, charge_gauge_pkg::AVERAGED_OFS, 32'h10);
        wait_evt(charge_gauge_pkg::VOLT, 1'b1);
        rdchk(charge_gauge_pkg::SOC_OFS, {16'h0, TOP_SOC});
        // One 1/16 step from 0x10 towards a rate sample of 0x100
        rdchk(charge_gauge_pkg::AVERAGED_OFS, 32'h1F);
        stop_test();
    end
endmodule // tb
